// ### design/scqsp_pkg.sv
// Purpose: Shared constants for the signaling change queue and slip phase.
// Assumes: 8-bit register port, 32 channels, 200 MHz ref_clk.
// Notes:   Register offsets are byte addresses on the parallel port.
package scqsp_pkg;
    localparam logic [7:0] ADDR_QUEUE   = 8'hda;
    localparam logic [7:0] ADDR_RXPHASE = 8'hdb;
    localparam logic [7:0] ADDR_TXPHASE = 8'hdc;
    localparam int         CHAN_W       = 5;
    localparam int         NUM_CHAN     = 32;
    localparam int         QUEUE_DEPTH  = 32;
    localparam int         PTR_W        = 5;
    localparam int         WORD_BIT     = 7;
    localparam int         MORE_BIT     = 6;
    localparam logic [7:0] RESET_BYTE   = 8'h00;
    localparam logic [5:0] RESET_DELAY  = 6'h00;
    typedef enum logic [1:0] {
        SCQSP_WORD0 = 2'b00,
        SCQSP_WORD1 = 2'b01
    } scqsp_word_t;
endpackage

// ### design/scqsp_evt_if.sv
// Purpose: Carrier for a signaling change event from detector to queue.
// Assumes: One event at most per clock.
// Notes:   Valid is a one-cycle pulse.
`timescale 1ns/1ps
interface scqsp_evt_if;
    logic       valid;
    logic [4:0] chan;
    logic [3:0] abcd;
    modport src (output valid, output chan, output abcd);
    modport dst (input valid, input chan, input abcd);
endinterface

// ### design/scqsp_change_detect.sv
// Purpose: Compare buffered input and output ABCD per channel after D update.
// Assumes: Update strobe marks the write of a channel's D bit.
// Notes:   Output buffer value is reported so it matches the channel buffer.
`timescale 1ns/1ps
module scqsp_change_detect (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       dUpdate,
    input  wire logic [4:0] updChan,
    input  wire logic [3:0] inAbcd,
    input  wire logic [3:0] outAbcd,
    input  wire logic [31:0] queueEnable,
    scqsp_evt_if.src        evt
);
    logic       next_valid;
    logic [4:0] next_chan;
    logic [3:0] next_abcd;

    // Per-channel compare, only on this channel's D update
    always_comb begin
        next_valid = dUpdate && queueEnable[updChan]
                     && (inAbcd != outAbcd);
        next_chan  = updChan;
        next_abcd  = outAbcd;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            evt.valid <= 1'b0;
            evt.chan  <= 5'h00;
            evt.abcd  <= 4'h0;
        end else begin
            evt.valid <= next_valid;
            evt.chan  <= next_chan;
            evt.abcd  <= next_abcd;
        end
    end

    // A disabled channel must never reach the queue
    property p_detect;
        @(posedge ref_clk) disable iff (rst)
        dUpdate && !queueEnable[updChan] |=> !evt.valid;
    endproperty
    a_detect: assert property (p_detect) else $error("off channel");
endmodule

// ### design/scqsp_top.sv
// Purpose: Signaling change queue and slip buffer phase status.
// Assumes: Host strobe rdStrobe is synchronous, one cycle per read.
// Notes:   Full queue drops new changes until drained.
`timescale 1ns/1ps
module scqsp_top (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        softReset,
    input  wire logic        rdStrobe,
    input  wire logic [7:0]  addr,
    output logic      [7:0]  rdData,
    input  wire logic        dUpdate,
    input  wire logic [4:0]  updChan,
    input  wire logic [3:0]  inAbcd,
    input  wire logic [3:0]  outAbcd,
    input  wire logic [31:0] change_queue_enable,
    input  wire logic        multiframeEnd,
    output logic             rx_signaling_change_irq,
    input  wire logic        rx_frame_irq,
    input  wire logic        tx_frame_irq,
    input  wire logic [5:0]  rxDelayIn,
    input  wire logic [5:0]  txDelayIn,
    input  wire logic        rxFillHalf,
    input  wire logic        rxDrainHalf,
    input  wire logic        tx_buffer_drain_half,
    input  wire logic        tx_buffer_fill_half,
    output logic             queueOverflow
);
    scqsp_evt_if evt ();

    scqsp_change_detect u_det (
        .ref_clk     (ref_clk),
        .rst         (rst),
        .dUpdate     (dUpdate),
        .updChan     (updChan),
        .inAbcd      (inAbcd),
        .outAbcd     (outAbcd),
        .queueEnable (change_queue_enable),
        .evt         (evt)
    );

    // Queue storage: QUEUE_DEPTH entries, one per queued change
    logic [4:0] qChan [scqsp_pkg::QUEUE_DEPTH];
    logic [3:0] qAbcd [scqsp_pkg::QUEUE_DEPTH];

    logic [scqsp_pkg::PTR_W-1:0] wrPtr, rdPtr, next_wrPtr, next_rdPtr;
    logic [scqsp_pkg::PTR_W:0]   count, next_count;
    scqsp_pkg::scqsp_word_t      wordSel, next_wordSel;
    logic                        changeSeen, next_changeSeen;
    logic                        next_irq;
    logic                        next_ovf;
    logic [7:0]                  next_rdData;
    logic [5:0]                  rxDelay, txDelay, next_rxDelay, next_txDelay;
    logic [1:0]                  rxHalf, txHalf, next_rxHalf, next_txHalf;
    logic                        push, pop, qEmpty, qFull;

    // Entry pops when the ABCD word is read
    always_comb begin
        qEmpty = (count == '0);
        qFull  = (count == (scqsp_pkg::PTR_W+1)'(scqsp_pkg::QUEUE_DEPTH));
        push   = evt.valid && !qFull;
        pop    = rdStrobe && addr == scqsp_pkg::ADDR_QUEUE
                 && wordSel == scqsp_pkg::SCQSP_WORD1 && !qEmpty;
    end

    // Pointer, word sequencing and interrupt next state
    always_comb begin
        next_wrPtr      = push ? wrPtr + 1'b1 : wrPtr;
        next_rdPtr      = pop  ? rdPtr + 1'b1 : rdPtr;
        next_count      = count + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
        next_wordSel    = wordSel;
        next_ovf        = queueOverflow | (evt.valid && qFull);
        if (rdStrobe && addr == scqsp_pkg::ADDR_QUEUE) begin
            if (wordSel == scqsp_pkg::SCQSP_WORD0 && !qEmpty)
                next_wordSel = scqsp_pkg::SCQSP_WORD1;
            else
                next_wordSel = scqsp_pkg::SCQSP_WORD0;
        end
        // Change flag: set wins if a change lands on the multiframe end
        next_changeSeen = (changeSeen && !multiframeEnd) | push;
        next_irq        = multiframeEnd && (changeSeen || push);
        if (softReset) begin
            next_wrPtr      = '0;
            next_rdPtr      = '0;
            next_count      = '0;
            next_wordSel    = scqsp_pkg::SCQSP_WORD0;
            next_changeSeen = 1'b0;
            next_ovf        = 1'b0;
        end
    end

    // Read data: word 0 or word 1; empty queue reads word 0 with MORE=0
    always_comb begin
        next_rdData = scqsp_pkg::RESET_BYTE;
        unique case (addr)
            scqsp_pkg::ADDR_QUEUE: begin
                if (wordSel == scqsp_pkg::SCQSP_WORD1) begin
                    next_rdData[scqsp_pkg::WORD_BIT] = 1'b1;
                    next_rdData[scqsp_pkg::MORE_BIT] =
                        (count > 1);
                    next_rdData[3:0] = qAbcd[rdPtr];
                end else if (!qEmpty) begin
                    next_rdData[scqsp_pkg::MORE_BIT] = 1'b1;
                    next_rdData[4:0] = qChan[rdPtr];
                end
            end
            scqsp_pkg::ADDR_RXPHASE: next_rdData = {rxDelay, rxHalf};
            scqsp_pkg::ADDR_TXPHASE: next_rdData = {txDelay, txHalf};
            default: next_rdData = scqsp_pkg::RESET_BYTE;
        endcase
    end

    // Delay fields latch once per frame with the frame interrupts; half bits register every cycle
    always_comb begin
        next_rxDelay = rx_frame_irq ? rxDelayIn : rxDelay;
        next_txDelay = tx_frame_irq ? txDelayIn : txDelay;
        next_rxHalf  = {rxDrainHalf, rxFillHalf};
        next_txHalf  = {tx_buffer_drain_half,
                        tx_buffer_fill_half};
    end

    // Storage write is not reset; pointers guard stale data
    always_ff @(posedge ref_clk) begin
        if (push) begin
            qChan[wrPtr] <= evt.chan;
            qAbcd[wrPtr] <= evt.abcd;
        end
    end

    // State registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wrPtr                   <= '0;
            rdPtr                   <= '0;
            count                   <= '0;
            wordSel                 <= scqsp_pkg::SCQSP_WORD0;
            changeSeen              <= 1'b0;
            rx_signaling_change_irq <= 1'b0;
            queueOverflow           <= 1'b0;
            rdData                  <= scqsp_pkg::RESET_BYTE;
            rxDelay                 <= scqsp_pkg::RESET_DELAY;
            txDelay                 <= scqsp_pkg::RESET_DELAY;
            rxHalf                  <= 2'h0;
            txHalf                  <= 2'h0;
        end else begin
            wrPtr                   <= next_wrPtr;
            rdPtr                   <= next_rdPtr;
            count                   <= next_count;
            wordSel                 <= next_wordSel;
            changeSeen              <= next_changeSeen;
            rx_signaling_change_irq <= next_irq;
            queueOverflow           <= next_ovf;
            rdData                  <= next_rdData;
            rxDelay                 <= next_rxDelay;
            txDelay                 <= next_txDelay;
            rxHalf                  <= next_rxHalf;
            txHalf                  <= next_txHalf;
        end
    end

    // Checks
    property p_word0;
        @(posedge ref_clk) disable iff (rst)
        rdStrobe && addr == scqsp_pkg::ADDR_QUEUE && !qEmpty
            && wordSel == scqsp_pkg::SCQSP_WORD0
        |=> rdData[7:5] == 3'b010 && rdData[4:0] == $past(qChan[rdPtr]);
    endproperty
    a_word0: assert property (p_word0) else $error("bad word 0");

    property p_word1;
        @(posedge ref_clk) disable iff (rst)
        rdStrobe && addr == scqsp_pkg::ADDR_QUEUE
            && wordSel == scqsp_pkg::SCQSP_WORD1
        |=> rdData[7] && rdData[6] == ($past(count) > 1);
    endproperty
    a_word1: assert property (p_word1) else $error("bad word 1");

    property p_pair;
        @(posedge ref_clk) disable iff (rst || softReset)
        rdStrobe && addr == scqsp_pkg::ADDR_QUEUE && !qEmpty
            && wordSel == scqsp_pkg::SCQSP_WORD0 && !softReset
        |=> wordSel == scqsp_pkg::SCQSP_WORD1;
    endproperty
    a_pair: assert property (p_pair) else $error("no word 1 next");

    property p_irq;
        @(posedge ref_clk) disable iff (rst)
        rx_signaling_change_irq |-> $past(multiframeEnd);
    endproperty
    a_irq: assert property (p_irq) else $error("irq off frame");

    property p_reset;
        @(posedge ref_clk) disable iff (rst)
        softReset |=> count == '0 && wrPtr == rdPtr;
    endproperty
    a_reset: assert property (p_reset) else $error("reset missed");

    property p_full;
        @(posedge ref_clk) disable iff (rst || softReset)
        evt.valid && qFull && !pop && !softReset
        |=> count == $past(count);
    endproperty
    a_full: assert property (p_full) else $error("full overrun");

    property p_rxdelay;
        @(posedge ref_clk) disable iff (rst)
        rx_frame_irq |=> rxDelay == $past(rxDelayIn);
    endproperty
    a_rxdelay: assert property (p_rxdelay) else $error("rx delay");

    property p_txdelay;
        @(posedge ref_clk) disable iff (rst)
        !tx_frame_irq |=> txDelay == $past(txDelay);
    endproperty
    a_txdelay: assert property (p_txdelay) else $error("tx delay");

    property p_phase;
        @(posedge ref_clk) disable iff (rst)
        1'b1 |=> rxHalf == $past({rxDrainHalf, rxFillHalf})
            && txHalf == $past({tx_buffer_drain_half, tx_buffer_fill_half});
    endproperty
    a_phase: assert property (p_phase) else $error("phase");

    // Second word carries the stored ABCD, unused bits low
    property p_abcd;
        @(posedge ref_clk) disable iff (rst)
        rdStrobe && addr == scqsp_pkg::ADDR_QUEUE
            && wordSel == scqsp_pkg::SCQSP_WORD1
        |=> rdData[5:4] == 2'b00 && rdData[3:0] == $past(qAbcd[rdPtr]);
    endproperty
    a_abcd: assert property (p_abcd) else $error("bad abcd");

    // An empty queue reads as zero, so MORE is clear
    property p_empty;
        @(posedge ref_clk) disable iff (rst)
        rdStrobe && addr == scqsp_pkg::ADDR_QUEUE && qEmpty
        |=> rdData == scqsp_pkg::RESET_BYTE;
    endproperty
    a_empty: assert property (p_empty) else $error("empty read");

    // Antecedents exclude soft reset: it overrides every count step
    property p_pop;
        @(posedge ref_clk) disable iff (rst)
        pop && !push && !softReset |=> count == $past(count) - 1;
    endproperty
    a_pop: assert property (p_pop) else $error("pop count");

    property p_push;
        @(posedge ref_clk) disable iff (rst)
        push && !pop && !softReset |=> count == $past(count) + 1;
    endproperty
    a_push: assert property (p_push) else $error("push count");

    property p_ovf;
        @(posedge ref_clk) disable iff (rst)
        evt.valid && qFull && !softReset |=> queueOverflow;
    endproperty
    a_ovf: assert property (p_ovf) else $error("no overflow");

    // Overflow is sticky until the software reset
    property p_sticky;
        @(posedge ref_clk) disable iff (rst)
        queueOverflow && !softReset |=> queueOverflow;
    endproperty
    a_sticky: assert property (p_sticky) else $error("ovf lost");

    // Pending change must raise the interrupt at multiframe end
    property p_mfirq;
        @(posedge ref_clk) disable iff (rst)
        multiframeEnd && changeSeen |=> rx_signaling_change_irq;
    endproperty
    a_mfirq: assert property (p_mfirq) else $error("irq missed");

    // Phase registers read back delay above the two half bits
    property p_rxread;
        @(posedge ref_clk) disable iff (rst)
        rdStrobe && addr == scqsp_pkg::ADDR_RXPHASE
        |=> rdData == $past({rxDelay, rxHalf});
    endproperty
    a_rxread: assert property (p_rxread) else $error("rx read");

    property p_txread;
        @(posedge ref_clk) disable iff (rst)
        rdStrobe && addr == scqsp_pkg::ADDR_TXPHASE
        |=> rdData == $past({txDelay, txHalf});
    endproperty
    a_txread: assert property (p_txread) else $error("tx read");

    property p_txfill;
        @(posedge ref_clk) disable iff (rst)
        1'b1 |=> txHalf[0] == $past(tx_buffer_fill_half);
    endproperty
    a_txfill: assert property (p_txfill) else $error("tx fill");

    c_push: cover property (@(posedge ref_clk) push);
    c_full: cover property (@(posedge ref_clk) qFull && evt.valid);
    c_irq:  cover property (@(posedge ref_clk) rx_signaling_change_irq);
    c_pop:  cover property (@(posedge ref_clk) pop && count == 1);
    c_ovf:  cover property (@(posedge ref_clk) queueOverflow && softReset);
endmodule

// ### dv/scqsp_host_model.sv
// Purpose: Host processor model on the parallel register port.
// Assumes: A read is taken at the edge that sees rdStrobe high.
// Notes:   Data is sampled just after the edge that takes the strobe.
`timescale 1ns/1ps
module scqsp_host_model (
    input  wire logic       ref_clk,
    input  wire logic [7:0] rdData,
    input  wire logic       irq,
    output logic            rdStrobe,
    output logic      [7:0] addr
);
    initial begin
        rdStrobe = 1'b0;
        addr     = 8'h00;
    end
    // One read, two words of an entry come from two such reads
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        rdStrobe <= 1'b1;
        addr     <= a;
        @(posedge ref_clk);
        rdStrobe <= 1'b0;
        #1 d = rdData;
    endtask
    // Poll the change interrupt before draining
    task automatic wait_irq(input int lim, output logic seen);
        seen = 1'b0;
        repeat (lim) begin
            #1;
            if (irq === 1'b1)
                seen = 1'b1;
            @(posedge ref_clk);
        end
    endtask
endmodule

// ### dv/tb_signaling_change_queue_and_slip_phase.sv
// Purpose: Self-checking bench for the change queue and phase status.
// Assumes: Host reads through the partner model only.
// Notes:   Drains use fixed entry counts; the more flag of each second word is checked.
`timescale 1ns/1ps
module tb_signaling_change_queue_and_slip_phase;
    logic        ref_clk;
    logic        rst;
    logic        softReset;
    logic        rdStrobe;
    logic [7:0]  addr;
    logic [7:0]  rdData;
    logic        dUpdate;
    logic [4:0]  updChan;
    logic [3:0]  inAbcd;
    logic [3:0]  outAbcd;
    logic [31:0] qEn;
    logic        mfEnd;
    logic        irq;
    logic        rxFrame;
    logic        txFrame;
    logic [5:0]  rxDly;
    logic [5:0]  txDly;
    logic [3:0]  halves;
    logic        ovf;
    logic [7:0]  d;
    logic        seen;
    int          n_errors;
    int          checked;

    scqsp_top dut (.ref_clk(ref_clk), .rst(rst), .softReset(softReset),
        .rdStrobe(rdStrobe), .addr(addr), .rdData(rdData),
        .dUpdate(dUpdate), .updChan(updChan), .inAbcd(inAbcd),
        .outAbcd(outAbcd), .change_queue_enable(qEn),
        .multiframeEnd(mfEnd), .rx_signaling_change_irq(irq),
        .rx_frame_irq(rxFrame), .tx_frame_irq(txFrame),
        .rxDelayIn(rxDly), .txDelayIn(txDly), .rxFillHalf(halves[2]),
        .rxDrainHalf(halves[3]), .tx_buffer_drain_half(halves[1]),
        .tx_buffer_fill_half(halves[0]), .queueOverflow(ovf));

    scqsp_host_model host (.ref_clk(ref_clk), .rdData(rdData), .irq(irq),
        .rdStrobe(rdStrobe), .addr(addr));

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Mark one channel's D-bit update with its buffered values
    task automatic upd(input logic [4:0] c, input logic [3:0] i, o);
        @(posedge ref_clk);
        dUpdate <= 1'b1;
        updChan <= c;
        inAbcd  <= i;
        outAbcd <= o;
        @(posedge ref_clk);
        dUpdate <= 1'b0;
    endtask

    // Close a multiframe, then look for the interrupt pulse
    task automatic mframe(input logic exp);
        @(posedge ref_clk);
        mfEnd <= 1'b1;
        @(posedge ref_clk);
        mfEnd <= 1'b0;
        host.wait_irq(4, seen);
        chk(8'(seen), 8'(exp));
    endtask

    // Read one entry and compare both words
    task automatic entry(input logic [4:0] c, input logic [3:0] v,
                         input logic more);
        host.rd(scqsp_pkg::ADDR_QUEUE, d);
        chk(d, {3'b010, c});
        host.rd(scqsp_pkg::ADDR_QUEUE, d);
        chk(d, {1'b1, more, 2'b00, v});
    endtask

    initial begin
        n_errors  = 0;
        checked   = 0;
        rst       = 1'b1;
        softReset = 1'b0;
        dUpdate   = 1'b0;
        updChan   = 5'h00;
        inAbcd    = 4'h0;
        outAbcd   = 4'h0;
        qEn       = 32'h0000_0000;
        mfEnd     = 1'b0;
        rxFrame   = 1'b0;
        txFrame   = 1'b0;
        rxDly     = 6'h00;
        txDly     = 6'h00;
        halves    = 4'h0;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        // Empty queue reads as a lone first word; unmapped reads zero
        host.rd(scqsp_pkg::ADDR_QUEUE, d);
        chk(d, 8'h00);
        host.rd(8'h5a, d);
        chk(d, 8'h00);
        // Channels 0, 5 and 31 selected; equal values never queue
        @(posedge ref_clk);
        qEn <= 32'h8000_0021;
        upd(5'd5, 4'h3, 4'hc);
        upd(5'd0, 4'h9, 4'h9);
        upd(5'd31, 4'h0, 4'ha);
        mframe(1'b1);
        entry(5'd5, 4'hc, 1'b1);
        entry(5'd31, 4'ha, 1'b0);
        host.rd(scqsp_pkg::ADDR_QUEUE, d);
        chk(d, 8'h00);
        // A change on an unselected channel leaves the multiframe quiet
        upd(5'd7, 4'h1, 4'h2);
        mframe(1'b0);
        // Fill all 32 places, then one more that must be dropped
        qEn <= 32'hffff_ffff;
        for (int i = 0; i < 33; i++)
            upd(i[4:0], ~i[3:0], i[3:0]);
        repeat (3) @(posedge ref_clk);
        chk(8'(ovf), 8'h01);
        for (int i = 0; i < 32; i++)
            entry(i[4:0], i[3:0], i != 31);
        // Software reset discards a pending entry and the overflow
        upd(5'd9, 4'h1, 4'h6);
        repeat (3) @(posedge ref_clk);
        softReset <= 1'b1;
        @(posedge ref_clk);
        softReset <= 1'b0;
        host.rd(scqsp_pkg::ADDR_QUEUE, d);
        chk(d, 8'h00);
        chk(8'(ovf), 8'h00);
        // Delay latched per frame pulse; halves follow their levels
        for (int k = 0; k < 4; k++) begin
            @(posedge ref_clk);
            rxDly   <= {3{k[1:0]}};
            txDly   <= ~{3{k[1:0]}};
            halves  <= {k[1:0], ~k[1:0]};
            rxFrame <= 1'b1;
            txFrame <= 1'b1;
            @(posedge ref_clk);
            rxFrame <= 1'b0;
            txFrame <= 1'b0;
            rxDly   <= ~rxDly;
            txDly   <= ~txDly;
            host.rd(scqsp_pkg::ADDR_RXPHASE, d);
            chk(d, {{3{k[1:0]}}, k[1:0]});
            host.rd(scqsp_pkg::ADDR_TXPHASE, d);
            chk(d, {~{3{k[1:0]}}, ~k[1:0]});
        end
        results();
    end

    // Watchdog: the sequence needs about 270 cycles
    initial begin
        #20000;
        n_errors++;
        results();
    end
endmodule
